// ### rtl/temp_regs_pkg.sv
// constants shared by the temperature value and limit register bank
// What this block does
// [RQ1] high-byte read freezes the matching low byte
// [RQ2] reading a frozen low byte releases it
// [RQ3] each high-byte read recaptures its low byte
// [RQ4] host reads high byte before low byte
// [RQ5] local high byte is signed two's complement
// [RQ6] local low: three fraction bits, rest zero
// [RQ7] remote fine bits only with filter enabled
// [RQ8] signed remote highs at 0x11, 0x12
// [RQ9] unsigned remote highs at 0x19, 0x1A
// [RQ10] local limit 0x40, resets 0x55, bit7 zero
// [RQ11] local limit decides local over-temperature event
// [RQ12] remote first limits 0x41, 0x42, reset 0x6E
// [RQ13] remote shared limits 0x49, 0x4A, reset 0x55
// [RQ14] hysteresis: five writable bits, top three zero
// [RQ15] read-only identity bytes at 0xFE, 0xFF
package temp_regs_pkg;

    localparam int NUM_TEMPS = 5;

    // index order: local, remote1 signed, remote2 signed, remote1 unsigned, remote2 unsigned
    localparam logic [7:0] HIGH_CMD [NUM_TEMPS] = '{8'h10, 8'h11, 8'h12, 8'h19, 8'h1A};
    localparam logic [7:0] LOW_CMD  [NUM_TEMPS] = '{8'h20, 8'h21, 8'h22, 8'h29, 8'h2A};

    localparam logic [7:0] CMD_LOCAL_LIMIT   = 8'h40;
    localparam logic [7:0] CMD_R1_FIRST      = 8'h41;
    localparam logic [7:0] CMD_R2_FIRST      = 8'h42;
    localparam logic [7:0] CMD_R1_SHARED     = 8'h49;
    localparam logic [7:0] CMD_R2_SHARED     = 8'h4A;
    localparam logic [7:0] CMD_HYSTERESIS    = 8'h5A;
    localparam logic [7:0] CMD_MAKER_ID      = 8'hFE;
    localparam logic [7:0] CMD_REVISION_IDENTITY   = 8'hFF;

    localparam logic [7:0] RST_LOCAL_LIMIT   = 8'h55;
    localparam logic [7:0] RST_FIRST_LIMIT   = 8'h6E;
    localparam logic [7:0] RST_SHARED_LIMIT  = 8'h55;
    localparam logic [7:0] RST_HYSTERESIS    = 8'h0A;

    localparam logic [7:0] MASK_LOCAL_LIMIT  = 8'h7F;
    localparam logic [7:0] MASK_FULL         = 8'hFF;
    localparam logic [7:0] MASK_HYSTERESIS   = 8'h1F;

    localparam logic [7:0] UNMAPPED_READ     = 8'h00;

    // converter result layout: high byte above the fraction bits
    localparam int LOCAL_FRAC_BITS  = 3;
    localparam int REMOTE_FRAC_BITS = 5;

endpackage : temp_regs_pkg

// ### rtl/host_access_if.sv
// command-byte access signals shared by the bank's register modules
`timescale 1ns/1ps
`default_nettype none
interface host_access_if;
    logic       rdStrobe;
    logic       wrStrobe;
    logic [7:0] addr;
    logic [7:0] wrData;

    modport source (output rdStrobe, output wrStrobe, output addr, output wrData);
    modport sink   (input rdStrobe, input wrStrobe, input addr, input wrData);
endinterface : host_access_if
`default_nettype wire

// ### rtl/low_byte_lock.sv
// low-byte freeze that keeps a low byte coherent with its high byte
`timescale 1ns/1ps
`default_nettype none
module low_byte_lock
    import temp_regs_pkg::*;
#(
    parameter logic [7:0] HIGH_ADDR = 8'h00,
    parameter logic [7:0] LOW_ADDR  = 8'h00
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    host_access_if.sink     acc,
    input  wire logic [7:0] liveLow,
    output logic      [7:0] shownLow
);
    logic       locked_reg;
    logic       locked_next;
    logic [7:0] held_reg;
    logic [7:0] held_next;
    logic       highRead;
    logic       lowRead;

    assign highRead = acc.rdStrobe && (acc.addr == HIGH_ADDR);
    assign lowRead  = acc.rdStrobe && (acc.addr == LOW_ADDR);

    always_comb begin
        locked_next = locked_reg;
        held_next   = held_reg;
        if (highRead) begin
            locked_next = 1'b1;      // [RQ1]
            held_next   = liveLow;   // [RQ3]
        end else if (lowRead) begin
            locked_next = 1'b0;      // [RQ2]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            locked_reg <= 1'b0;
            held_reg   <= 8'h00;
        end else begin
            locked_reg <= locked_next;
            held_reg   <= held_next;
        end
    end

    // the read that unlocks still sees the frozen value, since the top samples before the edge
    assign shownLow = locked_reg ? held_reg : liveLow;

    AST_LOCK_FREEZE: assert property (@(posedge mclk) disable iff (!rstn) // [RQ1] [RQ3]
        highRead |=> (shownLow == $past(liveLow)) && locked_reg)
        else $error("low byte not frozen after high-byte read");

    AST_LOCK_RELEASE: assert property (@(posedge mclk) disable iff (!rstn) // [RQ2]
        lowRead |=> !locked_reg && (shownLow == liveLow))
        else $error("low byte still frozen after low-byte read");

endmodule : low_byte_lock
`default_nettype wire

// ### rtl/limit_reg.sv
// one writable limit byte with a reset value and a mask of writable bits
`timescale 1ns/1ps
`default_nettype none
module limit_reg
    import temp_regs_pkg::*;
#(
    parameter logic [7:0] ADDR      = 8'h00,
    parameter logic [7:0] RST_VALUE = 8'h00,
    parameter logic [7:0] WR_MASK   = 8'hFF
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    host_access_if.sink     acc,
    output logic      [7:0] value
);
    logic [7:0] value_reg;
    logic [7:0] value_next;
    logic       hit;

    assign hit = acc.wrStrobe && (acc.addr == ADDR);

    always_comb begin
        value_next = value_reg;
        if (hit) begin
            value_next = acc.wrData & WR_MASK; // [RQ10] [RQ12] [RQ13] [RQ14]
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            value_reg <= RST_VALUE;
        end else begin
            value_reg <= value_next;
        end
    end

    assign value = value_reg;

    AST_LIMIT_WRITE: assert property (@(posedge mclk) disable iff (!rstn) // [RQ12] [RQ13]
        hit |=> value == ($past(acc.wrData) & WR_MASK))
        else $error("limit write not stored");

    AST_LIMIT_HOLD: assert property (@(posedge mclk) disable iff (!rstn) // [RQ14]
        !hit |=> $stable(value) && ((value & ~WR_MASK) == 8'h00))
        else $error("limit changed without write or reserved bit set");

endmodule : limit_reg
`default_nettype wire

// ### rtl/temp_value_limit_regs.sv
// temperature value and critical-limit register bank behind the command-byte port
`timescale 1ns/1ps
`default_nettype none
module temp_value_limit_regs
    import temp_regs_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A,  // arbitrary value
    parameter logic [7:0] REV_ID   = 8'h03   // arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [7:0]  cmdAddr,
    input  wire logic        rdStrobe,
    input  wire logic        wrStrobe,
    input  wire logic [7:0]  wrData,
    input  wire logic [10:0] localTemp,
    input  wire logic [12:0] remote1Signed,
    input  wire logic [12:0] remote2Signed,
    input  wire logic [12:0] remote1Unsigned,
    input  wire logic [12:0] remote2Unsigned,
    input  wire logic [1:0]  filterEnable,
    output logic      [7:0]  rdData,
    output logic             rdValid,
    output logic      [7:0]  localLimit,
    output logic      [7:0]  remote1FirstLimit,
    output logic      [7:0]  remote2FirstLimit,
    output logic      [7:0]  remote1SharedLimit,
    output logic      [7:0]  remote2SharedLimit,
    output logic      [7:0]  hysteresis,
    output logic             localOverTemp
);
    host_access_if acc ();

    assign acc.rdStrobe = rdStrobe;
    assign acc.wrStrobe = wrStrobe;
    assign acc.addr     = cmdAddr;
    assign acc.wrData   = wrData;

    logic [7:0] liveHigh [NUM_TEMPS];
    logic [7:0] liveLow  [NUM_TEMPS];
    logic [7:0] shownLow [NUM_TEMPS];

    // remote fine bits are only meaningful once the filter averages them
    function automatic logic [7:0] remoteLow(input logic [4:0] frac, input logic filt);
        remoteLow = {frac[4:2], frac[1:0] & {2{filt}}, 3'b000}; // [RQ7]
    endfunction : remoteLow

    always_comb begin
        liveHigh[0] = localTemp[10:LOCAL_FRAC_BITS];                  // [RQ5]
        liveLow[0]  = {localTemp[LOCAL_FRAC_BITS-1:0], 5'b0_0000};    // [RQ6]
        liveHigh[1] = remote1Signed[12:REMOTE_FRAC_BITS];             // [RQ8]
        liveLow[1]  = remoteLow(remote1Signed[REMOTE_FRAC_BITS-1:0], filterEnable[0]);
        liveHigh[2] = remote2Signed[12:REMOTE_FRAC_BITS];             // [RQ8]
        liveLow[2]  = remoteLow(remote2Signed[REMOTE_FRAC_BITS-1:0], filterEnable[1]);
        liveHigh[3] = remote1Unsigned[12:REMOTE_FRAC_BITS];           // [RQ9]
        liveLow[3]  = remoteLow(remote1Unsigned[REMOTE_FRAC_BITS-1:0], filterEnable[0]);
        liveHigh[4] = remote2Unsigned[12:REMOTE_FRAC_BITS];           // [RQ9]
        liveLow[4]  = remoteLow(remote2Unsigned[REMOTE_FRAC_BITS-1:0], filterEnable[1]);
    end

    genvar g;
    generate
        for (g = 0; g < NUM_TEMPS; g++) begin : gLock
            low_byte_lock #(
                .HIGH_ADDR (HIGH_CMD[g]),
                .LOW_ADDR  (LOW_CMD[g])
            ) uLock (
                .mclk     (mclk),
                .rstn     (rstn),
                .acc      (acc.sink),
                .liveLow  (liveLow[g]),
                .shownLow (shownLow[g])
            );
        end
    endgenerate

    limit_reg #(
        .ADDR      (CMD_LOCAL_LIMIT),
        .RST_VALUE (RST_LOCAL_LIMIT),
        .WR_MASK   (MASK_LOCAL_LIMIT)
    ) uLocalLimit (
        .mclk  (mclk),
        .rstn  (rstn),
        .acc   (acc.sink),
        .value (localLimit)
    );
    limit_reg #(
        .ADDR      (CMD_R1_FIRST),
        .RST_VALUE (RST_FIRST_LIMIT),
        .WR_MASK   (MASK_FULL)
    ) uR1First (
        .mclk  (mclk),
        .rstn  (rstn),
        .acc   (acc.sink),
        .value (remote1FirstLimit)
    );
    limit_reg #(
        .ADDR      (CMD_R2_FIRST),
        .RST_VALUE (RST_FIRST_LIMIT),
        .WR_MASK   (MASK_FULL)
    ) uR2First (
        .mclk  (mclk),
        .rstn  (rstn),
        .acc   (acc.sink),
        .value (remote2FirstLimit)
    );
    limit_reg #(
        .ADDR      (CMD_R1_SHARED),
        .RST_VALUE (RST_SHARED_LIMIT),
        .WR_MASK   (MASK_FULL)
    ) uR1Shared (
        .mclk  (mclk),
        .rstn  (rstn),
        .acc   (acc.sink),
        .value (remote1SharedLimit)
    );
    limit_reg #(
        .ADDR      (CMD_R2_SHARED),
        .RST_VALUE (RST_SHARED_LIMIT),
        .WR_MASK   (MASK_FULL)
    ) uR2Shared (
        .mclk  (mclk),
        .rstn  (rstn),
        .acc   (acc.sink),
        .value (remote2SharedLimit)
    );
    limit_reg #(
        .ADDR      (CMD_HYSTERESIS),
        .RST_VALUE (RST_HYSTERESIS),
        .WR_MASK   (MASK_HYSTERESIS)
    ) uHyst (
        .mclk  (mclk),
        .rstn  (rstn),
        .acc   (acc.sink),
        .value (hysteresis)
    );

    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    logic       rdValid_reg;
    logic       rdValid_next;
    logic [7:0] lastAddr_reg;
    logic [7:0] lastAddr_next;
    logic       overTemp_reg;
    logic       overTemp_next;

    always_comb begin
        rdValid_next  = rdStrobe;
        rdData_next   = rdData_reg;
        lastAddr_next = lastAddr_reg;
        // limit bit 7 is zero, so a signed compare covers the full local range
        overTemp_next = $signed(liveHigh[0]) > $signed(localLimit); // [RQ11]
        if (rdStrobe) begin
            lastAddr_next = cmdAddr;
            case (cmdAddr)
                CMD_LOCAL_LIMIT: rdData_next = localLimit;
                CMD_R1_FIRST:    rdData_next = remote1FirstLimit;
                CMD_R2_FIRST:    rdData_next = remote2FirstLimit;
                CMD_R1_SHARED:   rdData_next = remote1SharedLimit;
                CMD_R2_SHARED:   rdData_next = remote2SharedLimit;
                CMD_HYSTERESIS:  rdData_next = hysteresis;
                CMD_MAKER_ID:    rdData_next = MAKER_ID;  // [RQ15]
                CMD_REVISION_IDENTITY: rdData_next = REV_ID;    // [RQ15]
                default:         rdData_next = UNMAPPED_READ;
            endcase
            for (int i = 0; i < NUM_TEMPS; i++) begin
                if (cmdAddr == HIGH_CMD[i]) begin
                    rdData_next = liveHigh[i];
                end
                if (cmdAddr == LOW_CMD[i]) begin
                    rdData_next = shownLow[i]; // [RQ1] [RQ2]
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdData_reg   <= 8'h00;
            rdValid_reg  <= 1'b0;
            lastAddr_reg <= 8'h00;
            overTemp_reg <= 1'b0;
        end else begin
            rdData_reg   <= rdData_next;
            rdValid_reg  <= rdValid_next;
            lastAddr_reg <= lastAddr_next;
            overTemp_reg <= overTemp_next;
        end
    end

    assign rdData        = rdData_reg;
    assign rdValid       = rdValid_reg;
    assign localOverTemp = overTemp_reg;

    AST_READ_ANSWER: assert property (@(posedge mclk) disable iff (!rstn) // [RQ8]
        rdStrobe && (cmdAddr == HIGH_CMD[1]) |=> rdValid && (rdData == $past(remote1Signed[12:5])))
        else $error("signed remote high read wrong");

    AST_UNSIGNED_HIGH: assert property (@(posedge mclk) disable iff (!rstn) // [RQ9]
        rdStrobe && (cmdAddr == HIGH_CMD[4]) |=> rdData == $past(remote2Unsigned[12:5]))
        else $error("unsigned remote high read wrong");

    AST_LOCAL_HIGH: assert property (@(posedge mclk) disable iff (!rstn) // [RQ5]
        rdStrobe && (cmdAddr == HIGH_CMD[0]) |=> rdData == $past(localTemp[10:3]))
        else $error("local high read wrong");

    AST_LOCAL_LOW_ZERO: assert property (@(posedge mclk) disable iff (!rstn) // [RQ6]
        rdValid && (lastAddr_reg == LOW_CMD[0]) |-> rdData[4:0] == 5'b0_0000)
        else $error("local low reserved bits set");

    AST_FILTER_OFF: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
        rdValid && (lastAddr_reg == LOW_CMD[1]) && !$past(filterEnable[0]) && !$past(gLock[1].uLock.locked_reg)
        |-> rdData[4:0] == 5'b0_0000)
        else $error("remote fine bits shown with filter off");

    AST_LOCAL_LIMIT: assert property (@(posedge mclk) disable iff (!rstn) // [RQ10]
        localLimit[7] == 1'b0)
        else $error("local limit bit 7 set");

    AST_OVER_TEMP: assert property (@(posedge mclk) disable iff (!rstn) // [RQ11]
        localOverTemp == ($signed($past(localTemp[10:3])) > $signed($past(localLimit))))
        else $error("local over-temperature flag mismatch");

    AST_IDENTITY: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
        rdValid && (lastAddr_reg == CMD_MAKER_ID) |-> rdData == MAKER_ID)
        else $error("maker identity read wrong");

    AST_SIGNED2_HIGH: assert property (@(posedge mclk) disable iff (!rstn) // [RQ8]
        rdStrobe && (cmdAddr == HIGH_CMD[2]) |=> rdData == $past(remote2Signed[12:5]))
        else $error("signed remote 2 high read wrong");

    AST_UNSIGNED1_HIGH: assert property (@(posedge mclk) disable iff (!rstn) // [RQ9]
        rdStrobe && (cmdAddr == HIGH_CMD[3]) |=> rdData == $past(remote1Unsigned[12:5]))
        else $error("unsigned remote 1 high read wrong");

    AST_READ_PULSE: assert property (@(posedge mclk) disable iff (!rstn) // [RQ8]
        rdStrobe |=> rdValid)
        else $error("read not answered");

    AST_NO_READ_QUIET: assert property (@(posedge mclk) disable iff (!rstn) // [RQ8]
        !rdStrobe |=> !rdValid && $stable(rdData))
        else $error("read answer without read");

    AST_LOCAL_LIMIT_READ: assert property (@(posedge mclk) disable iff (!rstn) // [RQ10]
        rdStrobe && (cmdAddr == CMD_LOCAL_LIMIT) |=> rdData == $past(localLimit))
        else $error("local limit read wrong");

    AST_R1_FIRST_READ: assert property (@(posedge mclk) disable iff (!rstn) // [RQ12]
        rdStrobe && (cmdAddr == CMD_R1_FIRST) |=> rdData == $past(remote1FirstLimit))
        else $error("remote 1 first limit read wrong");

    AST_R2_FIRST_READ: assert property (@(posedge mclk) disable iff (!rstn) // [RQ12]
        rdStrobe && (cmdAddr == CMD_R2_FIRST) |=> rdData == $past(remote2FirstLimit))
        else $error("remote 2 first limit read wrong");

    AST_R1_SHARED_READ: assert property (@(posedge mclk) disable iff (!rstn) // [RQ13]
        rdStrobe && (cmdAddr == CMD_R1_SHARED) |=> rdData == $past(remote1SharedLimit))
        else $error("remote 1 shared limit read wrong");

    AST_R2_SHARED_READ: assert property (@(posedge mclk) disable iff (!rstn) // [RQ13]
        rdStrobe && (cmdAddr == CMD_R2_SHARED) |=> rdData == $past(remote2SharedLimit))
        else $error("remote 2 shared limit read wrong");

    AST_HYST_READ: assert property (@(posedge mclk) disable iff (!rstn) // [RQ14]
        rdStrobe && (cmdAddr == CMD_HYSTERESIS) |=> rdData == $past(hysteresis))
        else $error("hysteresis read wrong");

    AST_HYST_TOP_ZERO: assert property (@(posedge mclk) disable iff (!rstn) // [RQ14]
        hysteresis[7:5] == 3'b000)
        else $error("hysteresis top bits set");

    AST_REVISION: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
        rdValid && (lastAddr_reg == CMD_REVISION_IDENTITY) |-> rdData == REV_ID)
        else $error("revision identity read wrong");

    AST_ID_WRITE_IGNORED: assert property (@(posedge mclk) disable iff (!rstn) // [RQ15]
        wrStrobe && (cmdAddr == CMD_MAKER_ID) |=> $stable(localLimit) && $stable(hysteresis))
        else $error("identity write changed a limit");

    AST_REMOTE_LOW_RESERVED: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
        rdValid && ((lastAddr_reg == LOW_CMD[1]) || (lastAddr_reg == LOW_CMD[2]) || (lastAddr_reg == LOW_CMD[3])
        || (lastAddr_reg == LOW_CMD[4])) |-> rdData[2:0] == 3'b000)
        else $error("remote low reserved bits set");

    // peeks at the lock state keep these checks apart from the read mux they guard
    AST_FILTER_ON: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
        rdStrobe && (cmdAddr == LOW_CMD[2]) && filterEnable[1] && !gLock[2].uLock.locked_reg
        |=> rdData[4:3] == $past(remote2Signed[1:0]))
        else $error("remote fine bits missing with filter on");

    AST_FROZEN_LOW: assert property (@(posedge mclk) disable iff (!rstn) // [RQ1]
        rdStrobe && (cmdAddr == LOW_CMD[0]) && gLock[0].uLock.locked_reg
        |=> rdData == $past(gLock[0].uLock.held_reg))
        else $error("frozen local low not returned");

    AST_LIVE_LOW: assert property (@(posedge mclk) disable iff (!rstn) // [RQ2] [RQ6]
        rdStrobe && (cmdAddr == LOW_CMD[0]) && !gLock[0].uLock.locked_reg
        |=> rdData == {$past(localTemp[2:0]), 5'b0_0000})
        else $error("live local low read wrong");

    AST_UNSIGNED_LOW: assert property (@(posedge mclk) disable iff (!rstn) // [RQ7]
        rdStrobe && (cmdAddr == LOW_CMD[3]) && !gLock[3].uLock.locked_reg
        |=> rdData[7:5] == $past(remote1Unsigned[4:2]))
        else $error("unsigned remote low read wrong");

    AST_HIGH_READ_LOCKS: assert property (@(posedge mclk) disable iff (!rstn) // [RQ3]
        rdStrobe && (cmdAddr == HIGH_CMD[3]) |=> gLock[3].uLock.locked_reg)
        else $error("high read did not lock its low byte");

endmodule : temp_value_limit_regs
`default_nettype wire

// ### sim/host_model.sv
// host-side model that issues command-byte reads and writes to the bank
`timescale 1ns/1ps
`default_nettype none
module host_model
    import temp_regs_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic [7:0] rdData,
    input  wire logic       rdValid,
    output logic      [7:0] cmdAddr,
    output logic            rdStrobe,
    output logic            wrStrobe,
    output logic      [7:0] wrData
);
    initial begin
        cmdAddr  = 8'h00;
        rdStrobe = 1'b0;
        wrStrobe = 1'b0;
        wrData   = 8'h00;
    end

    // released lines go to the inverse so a stale value never passes for a held one
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge mclk);
        cmdAddr  = a;
        rdStrobe = 1'b1;
        @(negedge mclk);
        rdStrobe = 1'b0;
        cmdAddr  = ~a;
        v        = rdValid;
        d        = rdData;
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        cmdAddr  = a;
        wrData   = d;
        wrStrobe = 1'b1;
        @(negedge mclk);
        wrStrobe = 1'b0;
        cmdAddr  = ~a;
        wrData   = ~d;
    endtask : wr

    // coherent pair: high byte always goes first
    task automatic pair(input logic [7:0] hi, input logic [7:0] lo, output logic [7:0] h, output logic [7:0] l);
        logic v;
        rd(hi, h, v);
        rd(lo, l, v);
    endtask : pair
endmodule : host_model
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the temperature value and limit register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import temp_regs_pkg::*;
;
    typedef struct packed {logic isWr; logic [7:0] addr; logic [7:0] data; logic [7:0] expVal;} row_t;
    localparam logic [7:0] MAKER = 8'h3C;  // arbitrary value
    localparam logic [7:0] REV   = 8'hC3;  // arbitrary value
    localparam row_t ROWS [28] = '{
        {1'b0, 8'h40, 8'h00, 8'h55}, {1'b0, 8'h41, 8'h00, 8'h6E}, {1'b0, 8'h42, 8'h00, 8'h6E},
        {1'b0, 8'h49, 8'h00, 8'h55}, {1'b0, 8'h4A, 8'h00, 8'h55}, {1'b0, 8'h5A, 8'h00, 8'h0A},
        {1'b0, 8'hFE, 8'h00, MAKER}, {1'b0, 8'hFF, 8'h00, REV},   {1'b0, 8'h30, 8'h00, 8'h00},
        {1'b0, 8'h10, 8'h00, 8'hB4}, {1'b0, 8'h20, 8'h00, 8'hA0}, {1'b0, 8'h11, 8'h00, 8'hD5},
        {1'b0, 8'h21, 8'h00, 8'hF8}, {1'b0, 8'h12, 8'h00, 8'h53}, {1'b0, 8'h22, 8'h00, 8'h40},
        {1'b0, 8'h19, 8'h00, 8'hF9}, {1'b0, 8'h29, 8'h00, 8'h98}, {1'b0, 8'h1A, 8'h00, 8'h64},
        {1'b0, 8'h2A, 8'h00, 8'hA0}, {1'b1, 8'h40, 8'hFF, 8'h7F}, {1'b1, 8'h41, 8'hA5, 8'hA5},
        {1'b1, 8'h42, 8'h3C, 8'h3C}, {1'b1, 8'h49, 8'hC3, 8'hC3}, {1'b1, 8'h4A, 8'h81, 8'h81},
        {1'b1, 8'h5A, 8'hFF, 8'h1F}, {1'b1, 8'hFE, 8'h00, MAKER}, {1'b1, 8'h11, 8'h00, 8'hD5},
        {1'b1, 8'h30, 8'h77, 8'h00}};

    logic        mclk;
    logic        rstn;
    logic [7:0]  cmdAddr;
    logic        rdStrobe;
    logic        wrStrobe;
    logic [7:0]  wrData;
    logic [10:0] localTemp;
    logic [12:0] remote1Signed;
    logic [12:0] remote2Signed;
    logic [12:0] remote1Unsigned;
    logic [12:0] remote2Unsigned;
    logic [1:0]  filterEnable;
    logic [7:0]  rdData;
    logic        rdValid;
    logic [7:0]  localLimit;
    logic [7:0]  remote1FirstLimit;
    logic [7:0]  remote2FirstLimit;
    logic [7:0]  remote1SharedLimit;
    logic [7:0]  remote2SharedLimit;
    logic [7:0]  hysteresis;
    logic        localOverTemp;
    logic [7:0]  d;
    logic [7:0]  h;
    logic        v;
    int          fails;
    int          checksDone;

    temp_value_limit_regs #(.MAKER_ID(MAKER), .REV_ID(REV)) DUT (
        .mclk(mclk), .rstn(rstn), .cmdAddr(cmdAddr), .rdStrobe(rdStrobe), .wrStrobe(wrStrobe),
        .wrData(wrData), .localTemp(localTemp), .remote1Signed(remote1Signed), .remote2Signed(remote2Signed),
        .remote1Unsigned(remote1Unsigned), .remote2Unsigned(remote2Unsigned), .filterEnable(filterEnable),
        .rdData(rdData), .rdValid(rdValid), .localLimit(localLimit), .remote1FirstLimit(remote1FirstLimit),
        .remote2FirstLimit(remote2FirstLimit), .remote1SharedLimit(remote1SharedLimit),
        .remote2SharedLimit(remote2SharedLimit), .hysteresis(hysteresis), .localOverTemp(localOverTemp));

    host_model host (
        .mclk(mclk), .rdData(rdData), .rdValid(rdValid), .cmdAddr(cmdAddr),
        .rdStrobe(rdStrobe), .wrStrobe(wrStrobe), .wrData(wrData));

    always #5 mclk = ~mclk;

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checksDone++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask : chk

    task automatic setLocal(input logic [10:0] t);
        @(negedge mclk);
        localTemp = t;
    endtask : setLocal

    task automatic closeOut();
        $display("checks %0d mismatches %0d", checksDone, fails);
        if (fails == 0 && checksDone > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : closeOut

    initial begin
        #50000;
        fails++;
        closeOut();
    end

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        fails = 0;
        checksDone = 0;
        localTemp = 11'h5A5;
        remote1Signed = 13'h1ABF;
        remote2Signed = 13'h0A6B;
        remote1Unsigned = 13'h1F33;
        remote2Unsigned = 13'h0C96;
        filterEnable = 2'b01;
        repeat (6) @(negedge mclk);
        rstn = 1'b1;
        for (int i = 0; i < 28; i++) begin
            if (ROWS[i].isWr) host.wr(ROWS[i].addr, ROWS[i].data);
            host.rd(ROWS[i].addr, d, v);
            chk("rdValid", 8'h01, {7'h00, v});
            chk("rdData", ROWS[i].expVal, d);
        end
        chk("localLimit", 8'h7F, localLimit);
        chk("remote1FirstLimit", 8'hA5, remote1FirstLimit);
        chk("remote2FirstLimit", 8'h3C, remote2FirstLimit);
        chk("remote1SharedLimit", 8'hC3, remote1SharedLimit);
        chk("remote2SharedLimit", 8'h81, remote2SharedLimit);
        chk("hysteresis", 8'h1F, hysteresis);
        // over-temperature: strict greater-than against the programmed limit
        host.wr(8'h40, 8'h1F);
        setLocal(11'h100);
        repeat (3) @(negedge mclk);
        chk("localOverTemp", 8'h01, {7'h00, localOverTemp});
        host.wr(8'h40, 8'h20);
        repeat (3) @(negedge mclk);
        chk("localOverTemp", 8'h00, {7'h00, localOverTemp});
        // freeze, release and re-freeze of the local low byte
        setLocal(11'h101);
        host.rd(8'h10, d, v);
        setLocal(11'h106);
        host.rd(8'h20, d, v);
        chk("frozenLow", 8'h20, d);
        host.rd(8'h20, d, v);
        chk("liveLow", 8'hC0, d);
        host.rd(8'h10, d, v);
        setLocal(11'h103);
        host.rd(8'h10, d, v);
        setLocal(11'h105);
        host.pair(8'h10, 8'h20, h, d);
        chk("refrozenLow", 8'hA0, d);
        setLocal(11'h103);
        host.rd(8'h10, d, v);
        setLocal(11'h105);
        host.rd(8'h10, d, v);
        setLocal(11'h106);
        host.rd(8'h20, d, v);
        chk("recapturedLow", 8'hA0, d);
        // filter gating applies to the live low byte, not to one frozen by a high-byte read
        host.rd(8'h11, d, v);
        @(negedge mclk);
        filterEnable = 2'b00;
        host.rd(8'h21, d, v);
        chk("remoteFrozenLow", 8'hF8, d);
        host.rd(8'h21, d, v);
        chk("remoteLiveLow", 8'hE0, d);
        filterEnable = 2'b10;
        host.rd(8'h22, d, v);
        chk("remote2FilterLow", 8'h58, d);
        // second reset in mid-run restores limits
        @(negedge mclk);
        rstn = 1'b0;
        repeat (2) @(negedge mclk);
        chk("localLimit", 8'h55, localLimit);
        chk("hysteresis", 8'h0A, hysteresis);
        rstn = 1'b1;
        host.rd(8'h41, d, v);
        chk("rdData", 8'h6E, d);
        closeOut();
    end
endmodule : tb_top
`default_nettype wire
